/* File: design/bcw_pkg.sv */
package bcw_pkg;

   // Register byte addresses (printed offset 0x4 is word aligned)
   localparam logic [7:0]  ADDR_CTRL_WORD   = 8'h04;
   localparam logic [7:0]  ADDR_CONFIG2     = 8'h08;
   localparam logic [7:0]  ADDR_TIME_TAG    = 8'h0C;
   localparam logic [7:0]  ADDR_MSG_DATA    = 8'h10;
   localparam logic [7:0]  ADDR_CMD         = 8'h14;
   localparam logic [7:0]  ADDR_MSG_STATUS  = 8'h18;
   localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h1C;
   localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h20;

   localparam logic [15:0] CTRL_WORD_RESET  = 16'h0000;
   localparam logic [15:0] CONFIG2_RESET    = 16'h0000;
   localparam logic [1:0]  IRQ_MASK_RESET   = 2'h0;

   // Control word fields
   localparam int BIT_SYNC_TT     = 15;
   localparam int BIT_ME_IGN      = 14;
   localparam int BIT_SRQ_IGN     = 13;
   localparam int BIT_BUSY_IGN    = 12;
   localparam int BIT_SSF_IGN     = 11;
   localparam int BIT_TF_IGN      = 10;
   localparam int BIT_RSV_IGN     = 9;
   localparam int BIT_RETRY       = 8;
   localparam int BIT_BUS_SEL     = 7;
   localparam int BIT_LOOPBACK    = 6;
   localparam int BIT_BCR_IGN     = 5;
   localparam int BIT_EOM_IRQ     = 4;
   localparam int BIT_STD_SEL     = 3;
   // Config register 2 time tag enable for sync data
   localparam int CFG2_BIT_TT_SYNC = 5;

   // Terminal status word bit positions
   localparam int SW_ME   = 10;
   localparam int SW_SRQ  = 8;
   localparam int SW_RSV_HI = 7;
   localparam int SW_RSV_LO = 5;
   localparam int SW_BCR  = 4;
   localparam int SW_BUSY = 3;
   localparam int SW_SSF  = 2;
   localparam int SW_TF   = 0;

   // Command register bits
   localparam int CMD_BIT_START   = 0;
   localparam int CMD_BIT_RESP    = 1;
   localparam int CMD_BIT_FAIL    = 2;

   // Interrupt status bits
   localparam int IRQ_BIT_EOM     = 0;
   localparam int IRQ_BIT_FMT_ERR = 1;

   typedef enum logic [2:0] {
      FMT_BC_TO_RT     = 3'h0,
      FMT_RT_TO_RT     = 3'h1,
      FMT_BROADCAST    = 3'h2,
      FMT_BCAST_RT_RT  = 3'h3,
      FMT_MODE_CODE    = 3'h4,
      FMT_UNUSED_5     = 3'h5,
      FMT_BCAST_MODE   = 3'h6,
      FMT_UNUSED_7     = 3'h7
   } message_format_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACTIVE,
      ST_DONE
   } seq_state_e;

   typedef struct packed {
      logic            sync_data_from_timetag;
      logic            msg_error_status_ignore;
      logic            service_req_status_ignore;
      logic            busy_status_ignore;
      logic            subsystem_flag_ignore;
      logic            terminal_flag_ignore;
      logic            reserved_status_ignore;
      logic            retry_enable;
      logic            bus_select;
      logic            offline_loopback_test;
      logic            broadcast_rcvd_ignore;
      logic            end_of_message_irq_enable;
      logic            standard_select;
      message_format_e message_format;
   } ctrl_word_s;

   // Decoded message attributes handed to the sequencer
   typedef struct packed {
      logic            use_bus_a;
      logic            use_bus_b;
      logic            tx_disable;
      logic            loopback;
      logic            retry_enable;
      logic            std_1553a;
      logic            eom_irq_enable;
      logic [15:0]     sync_data_word;
      message_format_e format;
      logic            format_valid;
      logic            is_broadcast;
      logic            is_mode_code;
      logic            is_rt_to_rt;
   } msg_attr_s;

   typedef struct packed {
      logic msg_error;
      logic service_req;
      logic busy;
      logic subsystem_flag;
      logic terminal_flag;
      logic reserved;
      logic broadcast_rcvd;
      logic any;
   } status_flags_s;

   typedef struct packed {
      logic [15:0]     ctrl_word;
      logic [15:0]     config2;
      logic [15:0]     time_tag;
      logic [15:0]     msg_data;
      logic [15:0]     rt_status;
      status_flags_s   flags;
      logic            retry_req;
      logic [1:0]      irq_status;
      logic [1:0]      irq_mask;
      logic            pready;
      logic [31:0]     prdata;
      logic            pslverr;
      seq_state_e      state;
   } state_s;

endpackage

/* File: design/bc_msg_ctrl_word.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module bc_msg_ctrl_word (
   input  wire logic                I_CLOCK,
   input  wire logic                I_RST_N,
   input  wire logic                I_PSEL,
   input  wire logic                I_PENABLE,
   input  wire logic                I_PWRITE,
   input  wire logic [7:0]          I_PADDR,
   input  wire logic [31:0]         I_PWDATA,
   output logic                     O_PREADY,
   output logic      [31:0]         O_PRDATA,
   output logic                     O_PSLVERR,
   output bcw_pkg::msg_attr_s       O_ATTR,
   output bcw_pkg::status_flags_s   O_FLAGS,
   output logic                     O_RETRY_REQ,
   output logic                     O_IRQ
);

   bcw_pkg::state_s s_q;
   bcw_pkg::state_s s_d;
   bcw_pkg::ctrl_word_s cw;

   function automatic logic [31:0] rd_mux(
      input bcw_pkg::state_s st,
      input logic [7:0]      addr
   );
      logic [31:0] r;
      r = 32'h0000_0000;
      case (addr)
         bcw_pkg::ADDR_CTRL_WORD:  r = {16'h0000, st.ctrl_word};
         bcw_pkg::ADDR_CONFIG2:    r = {16'h0000, st.config2};
         bcw_pkg::ADDR_TIME_TAG:   r = {16'h0000, st.time_tag};
         bcw_pkg::ADDR_MSG_DATA:   r = {16'h0000, st.msg_data};
         bcw_pkg::ADDR_CMD:        r = 32'h0000_0000;
         bcw_pkg::ADDR_MSG_STATUS: r = {21'h000000, st.state,
                                        st.retry_req, st.flags};
         bcw_pkg::ADDR_IRQ_STATUS: r = {30'h0000_0000, st.irq_status};
         bcw_pkg::ADDR_IRQ_MASK:   r = {30'h0000_0000, st.irq_mask};
         default:                  r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic addr_ok(input logic [7:0] addr);
      logic ok;
      ok = 1'b0;
      case (addr)
         bcw_pkg::ADDR_CTRL_WORD, bcw_pkg::ADDR_CONFIG2,
         bcw_pkg::ADDR_TIME_TAG, bcw_pkg::ADDR_MSG_DATA,
         bcw_pkg::ADDR_CMD, bcw_pkg::ADDR_MSG_STATUS,
         bcw_pkg::ADDR_IRQ_STATUS, bcw_pkg::ADDR_IRQ_MASK: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   assign cw = bcw_pkg::ctrl_word_s'(s_q.ctrl_word);

   always_comb begin
      logic        wr;
      logic        acc;
      logic        start;
      logic        resp;
      logic        fail;
      logic [15:0] sw;
      logic [1:0]  ev;
      logic [1:0]  clr;
      wr    = 1'b0;
      acc   = 1'b0;
      start = 1'b0;
      resp  = 1'b0;
      fail  = 1'b0;
      sw    = 16'h0000;
      ev    = 2'h0;
      clr   = 2'h0;
      s_d   = s_q;

      // One wait state: answer in the cycle after the first access cycle
      acc = I_PSEL && I_PENABLE && !s_q.pready;
      s_d.pready  = acc;
      s_d.pslverr = acc && !addr_ok(I_PADDR);
      s_d.prdata  = 32'h0000_0000;
      // Write lands at the edge where the master sees pready high
      wr = I_PSEL && I_PENABLE && s_q.pready && I_PWRITE &&
           addr_ok(I_PADDR);
      if (acc && !I_PWRITE) begin
         s_d.prdata = rd_mux(s_q, I_PADDR);
      end

      if (wr) begin
         case (I_PADDR)
            bcw_pkg::ADDR_CTRL_WORD: s_d.ctrl_word = I_PWDATA[15:0];
            bcw_pkg::ADDR_CONFIG2:   s_d.config2   = I_PWDATA[15:0];
            bcw_pkg::ADDR_TIME_TAG:  s_d.time_tag  = I_PWDATA[15:0];
            bcw_pkg::ADDR_MSG_DATA:  s_d.msg_data  = I_PWDATA[15:0];
            bcw_pkg::ADDR_CMD: begin
               start = I_PWDATA[bcw_pkg::CMD_BIT_START];
               resp  = I_PWDATA[bcw_pkg::CMD_BIT_RESP];
               fail  = I_PWDATA[bcw_pkg::CMD_BIT_FAIL];
               sw    = I_PWDATA[31:16];
            end
            bcw_pkg::ADDR_IRQ_STATUS: clr = I_PWDATA[1:0];
            bcw_pkg::ADDR_IRQ_MASK:   s_d.irq_mask = I_PWDATA[1:0];
            default: ;
         endcase
      end

      // Message sequence: start, then status word returned to finish
      case (s_q.state)
         bcw_pkg::ST_IDLE: begin
            if (start) begin
               s_d.state     = bcw_pkg::ST_ACTIVE;
               s_d.retry_req = 1'b0;
               s_d.flags     = '0;
               if (cw.message_format == bcw_pkg::FMT_UNUSED_5 ||
                   cw.message_format == bcw_pkg::FMT_UNUSED_7) begin
                  ev[bcw_pkg::IRQ_BIT_FMT_ERR] = 1'b1;
                  s_d.state = bcw_pkg::ST_IDLE;
               end
            end
         end
         bcw_pkg::ST_ACTIVE: begin
            if (resp) begin
               s_d.rt_status = sw;
               s_d.flags.msg_error = sw[bcw_pkg::SW_ME] &&
                                     !cw.msg_error_status_ignore;
               s_d.flags.service_req = sw[bcw_pkg::SW_SRQ] &&
                                       !cw.service_req_status_ignore;
               s_d.flags.busy = sw[bcw_pkg::SW_BUSY] &&
                                !cw.busy_status_ignore;
               s_d.flags.subsystem_flag = sw[bcw_pkg::SW_SSF] &&
                                          !cw.subsystem_flag_ignore;
               s_d.flags.terminal_flag = sw[bcw_pkg::SW_TF] &&
                                         !cw.terminal_flag_ignore;
               s_d.flags.reserved =
                  (|sw[bcw_pkg::SW_RSV_HI:bcw_pkg::SW_RSV_LO]) &&
                  !cw.reserved_status_ignore;
               s_d.flags.broadcast_rcvd = sw[bcw_pkg::SW_BCR] &&
                                          !cw.broadcast_rcvd_ignore;
               s_d.flags.any = s_d.flags.msg_error ||
                               s_d.flags.service_req ||
                               s_d.flags.busy ||
                               s_d.flags.subsystem_flag ||
                               s_d.flags.terminal_flag ||
                               s_d.flags.reserved ||
                               s_d.flags.broadcast_rcvd;
               s_d.retry_req = fail && cw.retry_enable;
               ev[bcw_pkg::IRQ_BIT_EOM] = cw.end_of_message_irq_enable;
               s_d.state = bcw_pkg::ST_DONE;
            end
         end
         bcw_pkg::ST_DONE: begin
            s_d.state = bcw_pkg::ST_IDLE;
         end
         default: s_d.state = bcw_pkg::ST_IDLE;
      endcase

      // Set wins over write-one-to-clear
      s_d.irq_status = (s_q.irq_status & ~clr) | ev;

      if (!I_RST_N) begin
         s_d = '0;
         s_d.ctrl_word = bcw_pkg::CTRL_WORD_RESET;
         s_d.config2   = bcw_pkg::CONFIG2_RESET;
         s_d.irq_mask  = bcw_pkg::IRQ_MASK_RESET;
         s_d.state     = bcw_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      s_q <= s_d;
   end

   // Attributes for the sequencer; control word itself leaves only through the APB read path
   always_comb begin
      O_ATTR = '0;
      O_ATTR.use_bus_a = cw.bus_select && !cw.offline_loopback_test;
      O_ATTR.use_bus_b = !cw.bus_select && !cw.offline_loopback_test;
      O_ATTR.tx_disable = cw.offline_loopback_test;
      O_ATTR.loopback   = cw.offline_loopback_test;
      O_ATTR.retry_enable = cw.retry_enable;
      O_ATTR.std_1553a  = cw.standard_select;
      O_ATTR.eom_irq_enable = cw.end_of_message_irq_enable;
      if (cw.sync_data_from_timetag &&
          s_q.config2[bcw_pkg::CFG2_BIT_TT_SYNC]) begin
         O_ATTR.sync_data_word = s_q.time_tag;
      end else begin
         O_ATTR.sync_data_word = s_q.msg_data;
      end
      O_ATTR.format = cw.message_format;
      O_ATTR.format_valid =
         cw.message_format != bcw_pkg::FMT_UNUSED_5 &&
         cw.message_format != bcw_pkg::FMT_UNUSED_7;
      O_ATTR.is_broadcast =
         cw.message_format == bcw_pkg::FMT_BROADCAST ||
         cw.message_format == bcw_pkg::FMT_BCAST_RT_RT ||
         cw.message_format == bcw_pkg::FMT_BCAST_MODE;
      O_ATTR.is_mode_code =
         cw.message_format == bcw_pkg::FMT_MODE_CODE ||
         cw.message_format == bcw_pkg::FMT_BCAST_MODE;
      O_ATTR.is_rt_to_rt =
         cw.message_format == bcw_pkg::FMT_RT_TO_RT ||
         cw.message_format == bcw_pkg::FMT_BCAST_RT_RT;
   end

   assign O_PREADY    = s_q.pready;
   assign O_PRDATA    = s_q.prdata;
   assign O_PSLVERR   = s_q.pslverr;
   assign O_FLAGS     = s_q.flags;
   assign O_RETRY_REQ = s_q.retry_req;
   assign O_IRQ       = |(s_q.irq_status & s_q.irq_mask);

endmodule

/* File: verification/bc_msg_ctrl_word_sva.sv */
`timescale 1ns/10ps
module bc_msg_ctrl_word_sva (
   input wire logic                   I_CLOCK,
   input wire logic                   I_RST_N,
   input wire logic                   I_PSEL,
   input wire logic                   I_PENABLE,
   input wire logic                   I_PWRITE,
   input wire logic [7:0]             I_PADDR,
   input wire logic [31:0]            I_PWDATA,
   input wire logic                   O_PREADY,
   input wire logic [31:0]            O_PRDATA,
   input wire logic                   O_PSLVERR,
   input wire bcw_pkg::msg_attr_s     O_ATTR,
   input wire bcw_pkg::status_flags_s O_FLAGS,
   input wire logic                   O_RETRY_REQ,
   input wire logic                   O_IRQ
);
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_RST_N);
   // Completing write to the control word
   sequence ctrl_wr_done;
      I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
         && I_PADDR == bcw_pkg::ADDR_CTRL_WORD;
   endsequence
   a_bus_exclusive: assert property (!(O_ATTR.use_bus_a && O_ATTR.use_bus_b))
      else $error("both buses selected");
   a_loopback_quiet: assert property (O_ATTR.loopback |->
      O_ATTR.tx_disable && !O_ATTR.use_bus_a && !O_ATTR.use_bus_b)
      else $error("loopback still transmits");
   a_fmt_valid: assert property (O_ATTR.format_valid ==
      (O_ATTR.format != 3'h5 && O_ATTR.format != 3'h7))
      else $error("format valid decode wrong");
   a_fmt_bcast: assert property (O_ATTR.is_broadcast ==
      (O_ATTR.format inside {3'h2, 3'h3, 3'h6}))
      else $error("broadcast decode wrong");
   a_bus_write: assert property (ctrl_wr_done |=>
      O_ATTR.use_bus_a == ($past(I_PWDATA[7]) && !$past(I_PWDATA[6])) &&
      O_ATTR.use_bus_b == (!$past(I_PWDATA[7]) && !$past(I_PWDATA[6])))
      else $error("bus select not from written word");
   a_retry_write: assert property (ctrl_wr_done |=>
      O_ATTR.retry_enable == $past(I_PWDATA[8]))
      else $error("retry enable not from written word");
   a_std_write: assert property (ctrl_wr_done |=>
      O_ATTR.std_1553a == $past(I_PWDATA[3]) &&
      O_ATTR.format == $past(I_PWDATA[2:0]))
      else $error("standard or format not from written word");
   a_eom_write: assert property (ctrl_wr_done |=>
      O_ATTR.eom_irq_enable == $past(I_PWDATA[4]))
      else $error("end of message enable wrong");
   a_flags_any: assert property (O_FLAGS.any == |O_FLAGS[7:1])
      else $error("any flag mismatch");
endmodule

bind bc_msg_ctrl_word bc_msg_ctrl_word_sva bc_msg_ctrl_word_sva_inst (
   .I_CLOCK, .I_RST_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
   .I_PWDATA, .O_PREADY, .O_PRDATA, .O_PSLVERR, .O_ATTR, .O_FLAGS,
   .O_RETRY_REQ, .O_IRQ);

/* File: verification/rt_status_model.sv */
`timescale 1ns/10ps
module rt_status_model #(
   parameter logic [4:0] RT_ADDR = 5'h03
) (
   input  wire logic [2:0]  i_pick,
   output logic      [15:0] o_status_word
);
   localparam int POS [7] = '{10, 8, 3, 2, 0, 6, 4};
   // Terminal address on top, one status bit chosen by i_pick raised when i_pick is below 7
   always_comb begin
      o_status_word = {RT_ADDR, 11'h000};
      if (i_pick < 3'h7) o_status_word[POS[i_pick]] = 1'b1;
   end
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   logic                   clk;
   logic                   rst_n;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [7:0]             paddr;
   logic [31:0]            pwdata;
   logic                   pready;
   logic [31:0]            prdata;
   logic                   pslverr;
   bcw_pkg::msg_attr_s     attr;
   bcw_pkg::status_flags_s flags;
   logic                   retry_req;
   logic                   irq;
   logic [2:0]             pick;
   logic [15:0]            rt_word;
   logic [31:0]            rd;
   logic                   rd_err;
   int                     err_count;
   int                     check_count;
   localparam int MPOS [7] = '{14, 13, 12, 11, 10, 9, 5};

   bc_msg_ctrl_word bc_msg_ctrl_word_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
      .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_ATTR(attr),
      .O_FLAGS(flags), .O_RETRY_REQ(retry_req), .O_IRQ(irq));
   rt_status_model rt_status_model_inst (.i_pick(pick),
      .o_status_word(rt_word));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Poll until pready is seen high; the watchdog ends it if pready never rises
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd     = prdata;
      rd_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic run_msg(input logic [15:0] cw, input logic [15:0] sw,
                          input logic fail);
      apb(1'b1, bcw_pkg::ADDR_CTRL_WORD, {16'h0000, cw});
      apb(1'b1, bcw_pkg::ADDR_CMD, 32'h0000_0001);
      apb(1'b1, bcw_pkg::ADDR_CMD, {sw, 13'h0000, fail, 2'b10});
      @(negedge clk);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pick = 3'h0;
      err_count = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, bcw_pkg::ADDR_CTRL_WORD, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(attr.use_bus_b, 1'b1);
      for (int f = 0; f < 8; f++) begin
         logic [15:0] cw;
         cw = {f[0] ? 13'h14B5 : 13'h0B4A, f[2:0]};
         apb(1'b1, bcw_pkg::ADDR_CTRL_WORD, {16'h0000, cw});
         apb(1'b0, bcw_pkg::ADDR_CTRL_WORD, 32'h0000_0000);
         chk(rd, {16'h0000, cw});
         chk(attr.format_valid, f != 5 && f != 7);
         chk(attr.is_mode_code, f == 4 || f == 6);
         chk(attr.is_rt_to_rt, f == 1 || f == 3);
         chk(attr.retry_enable, cw[8]);
         chk(attr.std_1553a, cw[3]);
         chk(attr.eom_irq_enable, cw[4]);
         chk(attr.loopback, cw[6]);
         chk(attr.use_bus_a, cw[7] & ~cw[6]);
         chk(attr.tx_disable, cw[6]);
         chk(attr.format, f[2:0]);
         chk(attr.is_broadcast, f == 2 || f == 3 || f == 6);
      end
      for (int i = 0; i < 7; i++) begin
         pick = i[2:0];
         @(posedge clk);
         run_msg(16'h0000, rt_word, 1'b0);
         chk(flags, (8'h80 >> i) | 8'h01);
         run_msg(16'h0001 << MPOS[i], rt_word, 1'b0);
         chk(flags, 8'h00);
      end
      run_msg(16'h0100, 16'h0000, 1'b1);
      chk(retry_req, 1'b1);
      run_msg(16'h0000, 16'h0000, 1'b1);
      chk(retry_req, 1'b0);
      apb(1'b1, bcw_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      run_msg(16'h0010, 16'h0000, 1'b0);
      chk(irq, 1'b1);
      apb(1'b1, bcw_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      @(negedge clk);
      chk(irq, 1'b0);
      run_msg(16'h0000, 16'h0000, 1'b0);
      chk(irq, 1'b0);
      apb(1'b1, bcw_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      run_msg(16'h0010, 16'h0000, 1'b0);
      apb(1'b0, bcw_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
      chk({rd[1:0], irq}, 3'h2);
      apb(1'b1, bcw_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
      apb(1'b1, bcw_pkg::ADDR_MSG_DATA, 32'h0000_1234);
      apb(1'b1, bcw_pkg::ADDR_TIME_TAG, 32'h0000_ABCD);
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, bcw_pkg::ADDR_CONFIG2, {26'h0000000, s[1], 5'h00});
         apb(1'b1, bcw_pkg::ADDR_CTRL_WORD, {16'h0000, s[0], 15'h0004});
         @(negedge clk);
         chk(attr.sync_data_word, s == 3 ? 16'hABCD : 16'h1234);
      end
      apb(1'b1, bcw_pkg::ADDR_CTRL_WORD, 32'h0000_0005);
      apb(1'b1, bcw_pkg::ADDR_CMD, 32'h0000_0001);
      apb(1'b0, bcw_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      apb(1'b0, 8'h3C, 32'h0000_0000);
      chk(rd_err, 1'b1);
      chk(rd, 32'h0000_0000);
      give_verdict();
   end
endmodule
